// file: inc/cpts_pkg.sv
// Purpose : Shared constants for the priority level and trap status block
// Assumes : Avalon-MM byte addresses, one 32-bit word per register
// Notes   : Register data occupies the low 16 bits of each word
package cpts_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned CPTS_ADDR_W    = 4;
    localparam logic [3:0]  CPTS_OFS_ALU   = 4'h0;
    localparam logic [3:0]  CPTS_OFS_CORE  = 4'h4;
    localparam logic [3:0]  CPTS_OFS_INTC1 = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CPTS_PRIO_LSB  = 5;
    localparam int unsigned CPTS_TOP_BIT   = 3;
    localparam int unsigned CPTS_RSVD_BIT  = 2;
    localparam int unsigned CPTS_NEST_BIT  = 15;
    localparam int unsigned CPTS_TRAP_LSB  = 1;
    localparam int unsigned CPTS_ARITH_BIT = 4;
    localparam int unsigned CPTS_ADDR_BIT  = 3;
    localparam int unsigned CPTS_STACK_BIT = 2;
    localparam int unsigned CPTS_OSC_BIT   = 1;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  CPTS_PRIO_RST  = 3'h0;
    localparam logic        CPTS_TOP_RST   = 1'h0;
    localparam logic        CPTS_NEST_RST  = 1'h0;
    localparam logic [3:0]  CPTS_TRAP_RST  = 4'h0;
    localparam logic [2:0]  CPTS_PRIO_BLK  = 3'h7;
    localparam logic        CPTS_RSVD_VAL  = 1'h1;

    typedef enum {CPTS_BUS_IDLE, CPTS_BUS_ACK} cpts_bus_e;

endpackage : cpts_pkg

// file: inc/cpts_prio_if.sv
// Purpose : Carries the processor level to the source comparator and back
// Assumes : Single clock, combinational comparator
// Notes   : None
interface cpts_prio_if #(
    parameter int unsigned IDW = 3
);
    logic [3:0]     cpu_level;
    logic           block_all;
    logic           hit;
    logic [IDW-1:0] hit_id;
    logic [2:0]     hit_prio;

    modport ctrl (output cpu_level, output block_all,
                  input hit, input hit_id, input hit_prio);
    modport cmp  (input cpu_level, input block_all,
                  output hit, output hit_id, output hit_prio);
endinterface : cpts_prio_if

// file: src/cpts_src_cmp.sv
// Purpose : Picks the highest pending source above the processor level
// Assumes : Source requests and priorities come from same-clock logic
// Notes   : Ties go to the lowest source index
module cpts_src_cmp
    import cpts_pkg::*;
#(
    parameter int unsigned N_SRC = 8,
    parameter int unsigned IDW   = 3
) (
    input  wire logic [N_SRC-1:0]   src_req,
    input  wire logic [3*N_SRC-1:0] src_prio,
    cpts_prio_if.cmp                pif
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (IDW < 1 || (N_SRC > 1 && IDW < $clog2(N_SRC))) begin : g_bad_idw
        $error("IDW too narrow for N_SRC");
    end

    logic           best_hit;
    logic [IDW-1:0] best_id;
    logic [2:0]     best_prio;

    // ------------------------------------------------------------------
    // Strict compare against the four-bit level
    // ------------------------------------------------------------------
    always_comb begin
        best_hit  = 1'b0;
        best_id   = '0;
        best_prio = '0;
        for (int i = 0; i < N_SRC; i++) begin
            if (src_req[i] && !pif.block_all &&
                {1'b0, src_prio[3*i +: 3]} > pif.cpu_level &&
                (!best_hit || src_prio[3*i +: 3] > best_prio)) begin
                best_hit  = 1'b1;
                best_id   = IDW'(i);
                best_prio = src_prio[3*i +: 3];
            end
        end
    end

    assign pif.hit      = best_hit;
    assign pif.hit_id   = best_id;
    assign pif.hit_prio = best_prio;

endmodule : cpts_src_cmp

// file: src/cpts_top.sv
// Purpose : Processor priority level, nesting control and trap flags
// Assumes : Avalon-MM slave with waitrequest, 100 MHz clock
// Notes   : Register words hold 16 bits; upper half reads as zero
module cpts_top
    import cpts_pkg::*;
#(
    parameter int unsigned N_SRC = 8
) (
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire logic [CPTS_ADDR_W-1:0] address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [3:0]             byteenable,
    input  wire logic [31:0]            writedata,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    input  wire logic                   core_prio_load,
    input  wire logic [3:0]             core_prio_value,
    input  wire logic                   arith_trap,
    input  wire logic                   addr_trap,
    input  wire logic                   stack_trap,
    input  wire logic                   osc_loss_trap,
    input  wire logic [N_SRC-1:0]       src_req,
    input  wire logic [3*N_SRC-1:0]     src_prio,
    output logic      [3:0]             cpu_prio_level,
    output logic                        nesting_off,
    output logic                        irq_pending,
    output logic [((N_SRC>1)?$clog2(N_SRC):1)-1:0] irq_id,
    output logic      [2:0]             irq_prio
);

    localparam int unsigned IDW = (N_SRC > 1) ? $clog2(N_SRC) : 1;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (N_SRC < 1 || N_SRC > 128) begin : g_bad_n
        $error("N_SRC must lie between 1 and 128");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cpts_bus_e      bus_q;
    cpts_bus_e      bus_d;
    logic [2:0]     cpu_prio_low_q;
    logic [2:0]     cpu_prio_low_d;
    logic           cpu_prio_top_bit_q;
    logic           cpu_prio_top_bit_d;
    logic           nesting_off_q;
    logic           nesting_off_d;
    logic [3:0]     trap_q;
    logic [3:0]     trap_d;
    logic [31:0]    readdata_q;
    logic           irq_pending_q;
    logic [IDW-1:0] irq_id_q;
    logic [2:0]     irq_prio_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic req_any   = read | write;
    wire logic bus_idle  = (bus_q == CPTS_BUS_IDLE);
    wire logic bus_done  = (bus_q == CPTS_BUS_ACK);
    wire logic wr_go     = write & bus_done;
    wire logic sel_alu   = (address == CPTS_OFS_ALU);
    wire logic sel_core  = (address == CPTS_OFS_CORE);
    wire logic sel_intc1 = (address == CPTS_OFS_INTC1);
    wire logic lane_lo   = byteenable[0];
    wire logic lane_hi   = byteenable[1];

    assign waitrequest = req_any & ~bus_done;

    always_comb begin
        bus_d = bus_q;
        unique case (bus_q)
            CPTS_BUS_IDLE: begin
                if (req_any) begin
                    bus_d = CPTS_BUS_ACK;
                end
            end
            CPTS_BUS_ACK: begin
                bus_d = CPTS_BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Write strobes per register
    // ------------------------------------------------------------------
    wire logic sw_prio_wr = wr_go & sel_alu & lane_lo
                            & ~nesting_off_q;
    wire logic sw_top_clr = wr_go & sel_core & lane_lo
                            & ~writedata[CPTS_TOP_BIT];
    wire logic sw_nest_wr = wr_go & sel_intc1 & lane_hi;
    wire logic sw_trap_wr = wr_go & sel_intc1 & lane_lo;

    wire logic [3:0] trap_in = {arith_trap, addr_trap,
                                stack_trap, osc_loss_trap};
    wire logic [3:0] trap_base = sw_trap_wr
        ? writedata[CPTS_ARITH_BIT:CPTS_TRAP_LSB] : trap_q;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    assign cpu_prio_low_d = core_prio_load ? core_prio_value[2:0]
                          : sw_prio_wr
                          ? writedata[CPTS_PRIO_LSB +: 3]
                          : cpu_prio_low_q;
    assign cpu_prio_top_bit_d = core_prio_load ? core_prio_value[3]
                              : sw_top_clr ? 1'b0
                              : cpu_prio_top_bit_q;
    assign nesting_off_d = sw_nest_wr ? writedata[CPTS_NEST_BIT]
                                      : nesting_off_q;
    assign trap_d = trap_base | trap_in;

    // ------------------------------------------------------------------
    // Read data images
    // ------------------------------------------------------------------
    wire logic [31:0] img_alu   =
        32'(cpu_prio_low_q) << CPTS_PRIO_LSB;
    wire logic [31:0] img_core  =
        (32'(cpu_prio_top_bit_q) << CPTS_TOP_BIT) |
        (32'(CPTS_RSVD_VAL) << CPTS_RSVD_BIT);
    wire logic [31:0] img_intc1 =
        (32'(nesting_off_q) << CPTS_NEST_BIT) |
        (32'(trap_q) << CPTS_TRAP_LSB);
    wire logic [31:0] rd_mux = sel_alu   ? img_alu
                             : sel_core  ? img_core
                             : sel_intc1 ? img_intc1
                             : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Source comparator
    // ------------------------------------------------------------------
    cpts_prio_if #(.IDW(IDW)) pif ();

    assign pif.cpu_level = {cpu_prio_top_bit_q, cpu_prio_low_q};
    assign pif.block_all = (cpu_prio_low_q == CPTS_PRIO_BLK);

    cpts_src_cmp #(
        .N_SRC (N_SRC),
        .IDW   (IDW)
    ) u_cmp (
        .src_req  (src_req),
        .src_prio (src_prio),
        .pif      (pif.cmp)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_q      <= CPTS_BUS_IDLE;
            readdata_q <= 32'h0000_0000;
        end else begin
            bus_q <= bus_d;
            if (bus_idle && read) begin
                readdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_prio_low_q     <= CPTS_PRIO_RST;
            cpu_prio_top_bit_q <= CPTS_TOP_RST;
            nesting_off_q      <= CPTS_NEST_RST;
            trap_q             <= CPTS_TRAP_RST;
        end else begin
            cpu_prio_low_q     <= cpu_prio_low_d;
            cpu_prio_top_bit_q <= cpu_prio_top_bit_d;
            nesting_off_q      <= nesting_off_d;
            trap_q             <= trap_d;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_pending_q <= 1'b0;
            irq_id_q      <= '0;
            irq_prio_q    <= 3'h0;
        end else begin
            irq_pending_q <= pif.hit;
            irq_id_q      <= pif.hit_id;
            irq_prio_q    <= pif.hit_prio;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign readdata       = readdata_q;
    assign cpu_prio_level = {cpu_prio_top_bit_q, cpu_prio_low_q};
    assign nesting_off    = nesting_off_q;
    assign irq_pending    = irq_pending_q;
    assign irq_id         = irq_id_q;
    assign irq_prio       = irq_prio_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    level_hold_a: assert property (
        (wr_go && sel_alu && nesting_off_q && !core_prio_load)
        |=> $stable(cpu_prio_low_q))
        else $error("Level changed by software while nesting off");

    level_write_a: assert property (
        (wr_go && sel_alu && lane_lo && !nesting_off_q && !core_prio_load)
        |=> cpu_prio_low_q == $past(writedata[7:5]))
        else $error("Software level write not applied");

    block_all_a: assert property (
        (cpu_prio_low_q == 3'h7) |=> !irq_pending)
        else $error("Source passed while level field is 7");

    core_load_a: assert property (
        core_prio_load |=> cpu_prio_level == $past(core_prio_value))
        else $error("Core level load not applied");

    top_never_set_a: assert property (
        (!core_prio_load && !cpu_prio_top_bit_q) |=> !cpu_prio_top_bit_q)
        else $error("Top level bit rose without the core");

    strict_above_a: assert property (
        irq_pending |-> {1'b0, irq_prio} > $past(cpu_prio_level))
        else $error("Passed source not above processor level");

    arith_set_a: assert property (
        arith_trap |=> trap_q[3])
        else $error("Arithmetic trap flag not set");

    addr_set_a: assert property (
        addr_trap |=> trap_q[2])
        else $error("Address trap flag not set");

    stack_set_a: assert property (
        stack_trap |=> trap_q[1])
        else $error("Stack trap flag not set");

    osc_set_a: assert property (
        osc_loss_trap |=> trap_q[0])
        else $error("Oscillator loss trap flag not set");

    nest_write_a: assert property (
        sw_nest_wr |=> nesting_off == $past(writedata[15]))
        else $error("Nesting-off write not applied");

    core_image_a: assert property (
        (bus_done && read && sel_core)
        |-> readdata[2] && readdata[15:4] == 12'h000 && readdata[1:0] == 2'h0)
        else $error("Core control reserved bits wrong");

    intc1_image_a: assert property (
        (bus_done && read && sel_intc1)
        |-> readdata[14:5] == 10'h000 && !readdata[0])
        else $error("Control one unimplemented bits not zero");

    bus_answer_a: assert property (
        (req_any && bus_idle) |-> waitrequest ##1 !waitrequest)
        else $error("Bus answer not given in one cycle");

    trap_cover_c: cover property (arith_trap ##1 sw_trap_wr);
    nest_cover_c: cover property (nesting_off_q && wr_go && sel_alu);
    irq_cover_c:  cover property (irq_pending && cpu_prio_top_bit_q);

endmodule : cpts_top

// file: verification/cpts_core_model.sv
// Purpose : Core and source stand-in driving level loads, traps, requests
// Assumes : One clock, every output changes just after a rising edge
// Notes   : Traps index 3..0 are arith, addr, stack, osc loss
module cpts_core_model (
    output logic        prio_load,
    output logic [3:0]  prio_value,
    output logic [3:0]  traps,
    output logic [7:0]  req,
    output logic [23:0] prio,
    input  wire logic   clock
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        prio_load = 1'h0;
        prio_value = 4'h0;
        traps = 4'h0;
        req = 8'h0;
        prio = 24'h0;
    end

    task automatic load(input logic [3:0] v);
        @(posedge clock);
        prio_load <= 1'h1;
        prio_value <= v;
        @(posedge clock);
        prio_load <= 1'h0;
        prio_value <= ~v;
    endtask : load

    task automatic trap(input int i);
        @(posedge clock);
        traps <= 4'h1 << i;
        @(posedge clock);
        traps <= 4'h0;
    endtask : trap

    task automatic sources(input logic [7:0] r, input logic [23:0] p);
        @(posedge clock);
        req <= r;
        prio <= p;
    endtask : sources
endmodule : cpts_core_model

// file: verification/cpts_top_tb.sv
// Purpose : Self-checking bench for the level and trap status block
// Assumes : Avalon-MM master, one wait cycle expected but not assumed
// Notes   : Integer model of level, nesting bit, flags and source pick
module cpts_top_tb
    import cpts_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        reset;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        prio_load;
    logic [3:0]  prio_value;
    logic [3:0]  traps;
    logic [7:0]  src_req;
    logic [23:0] src_prio;
    logic [3:0]  cpu_prio_level;
    logic        nesting_off;
    logic        irq_pending;
    logic [2:0]  irq_id;
    logic [2:0]  irq_prio;
    logic [31:0] q;
    int          bad_count;
    int          samples_checked;
    int          lvl, nest, flags, r, p, l, best, bp, pv;

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    cpts_core_model u_core (.prio_load(prio_load), .prio_value(prio_value),
        .traps(traps), .req(src_req), .prio(src_prio), .clock(clock));

    cpts_top #(.N_SRC(8)) u_dut (.clock(clock), .reset(reset),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .core_prio_load(prio_load),
        .core_prio_value(prio_value), .arith_trap(traps[3]),
        .addr_trap(traps[2]), .stack_trap(traps[1]),
        .osc_loss_trap(traps[0]), .src_req(src_req), .src_prio(src_prio),
        .cpu_prio_level(cpu_prio_level), .nesting_off(nesting_off),
        .irq_pending(irq_pending), .irq_id(irq_id), .irq_prio(irq_prio));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {~d, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            bad_count++;
            wrap_up();
        end
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus(1'h0, a, 16'h0);
        check(q, {16'h0, e});
    endtask : rd

    task automatic verify;
        rd(CPTS_OFS_ALU, 16'((lvl % 8) << 5));
        rd(CPTS_OFS_CORE, 16'(((lvl / 8) << 3) | 4));
        rd(CPTS_OFS_INTC1, 16'((nest << 15) | (flags << 1)));
        check(32'(cpu_prio_level), 32'(lvl));
        check(32'(nesting_off), 32'(nest));
    endtask : verify

    initial begin
        reset = 1'h1;
        address = 4'h0;
        read = 1'h0;
        write = 1'h0;
        byteenable = 4'hf;
        writedata = 32'h0;
        bad_count = 0;
        samples_checked = 0;
        lvl = 0;
        nest = 0;
        flags = 0;
        void'($urandom(98171));
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        verify();
        rd(4'hc, 16'h0);
        $display("test reset done");
        for (int v = 0; v < 8; v++) begin
            bus(1'h1, CPTS_OFS_ALU, 16'hff1f | 16'(v << 5));
            lvl = v;
            verify();
        end
        $display("test level write done");
        u_core.load(4'hb);
        lvl = 11;
        verify();
        bus(1'h1, CPTS_OFS_ALU, 16'h00a0);
        lvl = 13;
        verify();
        bus(1'h1, CPTS_OFS_CORE, 16'h0000);
        lvl = 5;
        verify();
        bus(1'h1, CPTS_OFS_CORE, 16'hffff);
        verify();
        $display("test top bit done");
        bus(1'h1, CPTS_OFS_INTC1, 16'hffff);
        nest = 1;
        flags = 15;
        verify();
        bus(1'h1, CPTS_OFS_ALU, 16'h0020);
        verify();
        bus(1'h1, CPTS_OFS_INTC1, 16'h0000);
        nest = 0;
        flags = 0;
        verify();
        $display("test nesting done");
        byteenable <= 4'he;
        bus(1'h1, CPTS_OFS_ALU, 16'h00e0);
        byteenable <= 4'hf;
        verify();
        $display("test byte lanes done");
        for (int i = 0; i < 4; i++) begin
            u_core.trap(i);
            flags = 1 << i;
            verify();
            bus(1'h1, CPTS_OFS_INTC1, 16'h0000);
            flags = 0;
        end
        $display("test traps done");
        bus(1'h1, CPTS_OFS_INTC1, 16'hffff);
        reset <= 1'h1;
        repeat (2) @(posedge clock);
        reset <= 1'h0;
        lvl = 0;
        nest = 0;
        flags = 0;
        verify();
        $display("test mid reset done");
        for (int k = 0; k < 24; k++) begin
            r = $urandom % 256;
            p = $urandom % 16777216;
            l = (k == 0) ? 7 : $urandom % 16;
            u_core.load(4'(l));
            u_core.sources(8'(r), 24'(p));
            lvl = l;
            best = -1;
            bp = 0;
            for (int i = 0; i < 8; i++) begin
                pv = (p >> (3 * i)) % 8;
                if (((r >> i) % 2) == 1 && pv > l && pv > bp) begin
                    best = i;
                    bp = pv;
                end
            end
            if (l % 8 == 7) best = -1;
            repeat (3) @(posedge clock);
            #1;
            check(32'(irq_pending), 32'(best >= 0));
            if (best >= 0) begin
                check(32'(irq_id), 32'(best));
                check(32'(irq_prio), 32'(bp));
            end
        end
        $display("test source pick done");
        wrap_up();
    end
endmodule : cpts_top_tb
